/* shared/watchdog_reset_status_map.svh */
/*
 * register offsets, field positions, reset values and timing counts of the
 * watchdog and reset-cause block.
 * assumes the core presents byte addresses in data space or port space.
 */
`ifndef WATCHDOG_RESET_STATUS_MAP_SVH
`define WATCHDOG_RESET_STATUS_MAP_SVH

// register locations
`define RCF_DATA_ADDR 16'h0054
`define PORT_SPACE_OFFSET 16'h0020
`define RCF_PORT_ADDR 16'h0034
`define WDC_DATA_ADDR 16'h0060

// reset_cause_flags fields
`define RCF_DBG_BIT 4
`define RCF_WDT_BIT 3
`define RCF_BOD_BIT 2
`define RCF_EXT_BIT 1
`define RCF_POR_BIT 0
`define RCF_RESET 5'h01

// watchdog_control fields
`define WDC_IF_BIT 7
`define WDC_IE_BIT 6
`define WDC_PS3_BIT 5
`define WDC_CE_BIT 4
`define WDC_DE_BIT 3
`define WDC_PS_LO_MSB 2
`define WDC_RESET 8'h00

// timing
`define CE_WINDOW_CYCLES 3'h4
`define WDT_OSC_HZ 128000
`define WDT_BASE_CYCLES 21'h00_0800
`define WDT_MAX_CODE 4'h9

`endif

/* shared/watchdog_reset_status_pkg.sv */
/*
 * types shared by the watchdog and reset-cause block.
 * assumes the map header is compiled alongside.
 */
`default_nettype none
package watchdog_reset_status_pkg;

	// one access from the core
	typedef struct packed {
		logic [15:0] addr;
		logic port_space;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} core_access_t;

	// action on a timeout
	typedef enum logic [1:0] {
		WDT_STOPPED = 2'b00,
		WDT_IRQ = 2'b01,
		WDT_RESET = 2'b10,
		WDT_IRQ_RESET = 2'b11
	} wdt_mode_t;

	// all state of the block except the two reset-release registers
	typedef struct packed {
		logic [2:0] osc_sync;
		logic [1:0] ext_sync;
		logic [1:0] bod_sync;
		logic [1:0] dbg_sync;
		logic [1:0] fuse_sync;
		logic [4:0] flags;
		logic wif;
		logic wie;
		logic rst_en;
		logic wce;
		logic [2:0] ce_cnt;
		logic [3:0] prescale;
		logic [19:0] wdt_cnt;
		logic [7:0] rdata;
		logic sys_rst;
		logic irq;
	} wdt_state_t;

endpackage
`default_nettype wire

/* hw/watchdog_reset_status.sv */
/*
 * watchdog timer with reset-cause flags, reached by core data-space and
 * port-space accesses.
 * assumes core access strobes are on i_ref_clk; oscillator, fuse and
 * reset-source levels are asynchronous and synchronised here.
 */
// Summary of operation
// - debug-port reset sets flag; por/write-zero clears
// - watchdog reset sets flag; por/write-zero clears
// - brown-out reset sets flag; por/write-zero clears
// - external reset sets flag; por/write-zero clears
// - power-on sets flag; only write-zero clears
// - reset-cause at data 0x54, port 0x34
// - control at 0x60, data space only
// - irq-mode timeout sets flag; ack/write-one clears
// - irq requested when flag, enable, global set
// - enable bits select stopped, irq, reset modes
// - combined mode: ack clears enable and flag
// - combined mode: untaken irq, next timeout resets
// - programmed fuse forces reset mode always
// - change-enable gates changes, self-clears after four
// - watchdog reset flag holds reset enable high
// - prescale code picks 2048 to 1048576 oscillator cycles
// - prescale msb bit 5, low bits 2:0
// - counts slow oscillator; restart zeroes count
// - reset-mode timeout gives one-cycle reset pulse
`include "watchdog_reset_status_map.svh"
`default_nettype none

module watchdog_reset_status
	import watchdog_reset_status_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire core_access_t i_core_access,
	input wire logic i_wdt_restart,
	input wire logic i_irq_ack,
	input wire logic i_global_irq_enable,
	input wire logic i_wdt_osc,
	input wire logic i_always_on_fuse,
	input wire logic i_ext_reset,
	input wire logic i_brownout_reset,
	input wire logic i_debug_reset,
	output logic [7:0] o_rdata,
	output logic o_sys_reset,
	output logic o_wdt_irq
);

	////////////////////////////////////////////////////////////////////////
	// reset release
	logic rst_s1_reg;
	logic rst_ok_reg;

	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rst_s1_reg <= 1'b0;
			rst_ok_reg <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_ok_reg <= rst_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address decode
	wdt_state_t s_reg;
	wdt_state_t s_next;
	logic [15:0] data_addr;
	logic rcf_hit;
	logic wdc_hit;
	logic rcf_wr;
	logic wdc_wr;
	logic unlock_wr;
	logic fuse_prog;
	logic osc_edge;
	logic other_rst;
	logic rst_en_eff;
	logic wie_eff;
	logic timeout;
	logic [3:0] code_eff;
	logic [20:0] limit;
	logic [19:0] terminal;
	wdt_mode_t mode;
	localparam logic [7:0] wdc_reset_val = `WDC_RESET;

	always_comb
	begin
		data_addr = i_core_access.port_space ?
			16'(i_core_access.addr + `PORT_SPACE_OFFSET) : i_core_access.addr;
		rcf_hit = (data_addr == `RCF_DATA_ADDR);
		wdc_hit = !i_core_access.port_space && (i_core_access.addr == `WDC_DATA_ADDR);
		rcf_wr = rcf_hit && i_core_access.wr;
		wdc_wr = wdc_hit && i_core_access.wr;
		unlock_wr = wdc_wr && i_core_access.wdata[`WDC_CE_BIT]
			&& i_core_access.wdata[`WDC_DE_BIT];
	end

	////////////////////////////////////////////////////////////////////////
	// mode and timeout
	always_comb
	begin
		fuse_prog = !s_reg.fuse_sync[1];
		osc_edge = s_reg.osc_sync[1] && !s_reg.osc_sync[2];
		other_rst = s_reg.ext_sync[1] || s_reg.bod_sync[1] || s_reg.dbg_sync[1];
		rst_en_eff = s_reg.rst_en || fuse_prog;
		wie_eff = s_reg.wie && !fuse_prog;
		mode = wdt_mode_t'({rst_en_eff, wie_eff});
		code_eff = (s_reg.prescale > `WDT_MAX_CODE) ? `WDT_MAX_CODE : s_reg.prescale;
		limit = `WDT_BASE_CYCLES << code_eff;
		terminal = 20'(limit - 21'h00_0001);
		timeout = osc_edge && (mode != WDT_STOPPED) && !i_wdt_restart
			&& (s_reg.wdt_cnt == terminal);
	end

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		s_next = s_reg;
		s_next.osc_sync = {s_reg.osc_sync[1:0], i_wdt_osc};
		s_next.ext_sync = {s_reg.ext_sync[0], i_ext_reset};
		s_next.bod_sync = {s_reg.bod_sync[0], i_brownout_reset};
		s_next.dbg_sync = {s_reg.dbg_sync[0], i_debug_reset};
		s_next.fuse_sync = {s_reg.fuse_sync[0], i_always_on_fuse};
		s_next.sys_rst = 1'b0;

		// watchdog counter
		if (i_wdt_restart || mode == WDT_STOPPED || timeout)
			s_next.wdt_cnt = 20'h0_0000;
		else if (osc_edge)
			s_next.wdt_cnt = s_reg.wdt_cnt + 20'h0_0001;

		// change-enable window
		if (s_reg.wce)
		begin
			s_next.ce_cnt = s_reg.ce_cnt - 3'h1;
			if (s_reg.ce_cnt == 3'h1)
				s_next.wce = 1'b0;
		end

		// cause flags: software writes zero to clear
		if (rcf_wr)
			s_next.flags = s_reg.flags & i_core_access.wdata[4:0];

		// control writes
		if (wdc_wr)
		begin
			if (i_core_access.wdata[`WDC_IF_BIT])
				s_next.wif = 1'b0;
			s_next.wie = i_core_access.wdata[`WDC_IE_BIT];
			if (unlock_wr)
			begin
				s_next.rst_en = 1'b1;
				s_next.wce = 1'b1;
				s_next.ce_cnt = `CE_WINDOW_CYCLES;
			end
			else if (s_reg.wce)
			begin
				s_next.rst_en = i_core_access.wdata[`WDC_DE_BIT];
				s_next.prescale = {i_core_access.wdata[`WDC_PS3_BIT],
					i_core_access.wdata[`WDC_PS_LO_MSB:0]};
				s_next.wce = 1'b0;
				s_next.ce_cnt = 3'h0;
			end
			else if (i_core_access.wdata[`WDC_DE_BIT])
				s_next.rst_en = 1'b1;
		end

		// vector taken
		if (i_irq_ack)
		begin
			s_next.wif = 1'b0;
			if (rst_en_eff)
				s_next.wie = 1'b0;
		end

		// timeout action
		if (timeout)
		begin
			if (fuse_prog || (rst_en_eff && (!wie_eff || s_next.wif)))
				s_next.sys_rst = 1'b1;
			else
				s_next.wif = 1'b1;
		end

		// set sources win over software clears
		if (s_reg.sys_rst)
			s_next.flags[`RCF_WDT_BIT] = 1'b1;
		if (s_reg.ext_sync[1])
			s_next.flags[`RCF_EXT_BIT] = 1'b1;
		if (s_reg.bod_sync[1])
			s_next.flags[`RCF_BOD_BIT] = 1'b1;
		if (s_reg.dbg_sync[1])
			s_next.flags[`RCF_DBG_BIT] = 1'b1;

		// a system reset returns control to defaults
		if (s_reg.sys_rst || other_rst)
		begin
			s_next.wif = wdc_reset_val[`WDC_IF_BIT];
			s_next.wie = wdc_reset_val[`WDC_IE_BIT];
			s_next.rst_en = wdc_reset_val[`WDC_DE_BIT];
			s_next.wce = wdc_reset_val[`WDC_CE_BIT];
			s_next.prescale = {wdc_reset_val[`WDC_PS3_BIT], wdc_reset_val[`WDC_PS_LO_MSB:0]};
			s_next.ce_cnt = 3'h0;
			s_next.wdt_cnt = 20'h0_0000;
			s_next.sys_rst = 1'b0;
		end

		if (s_next.flags[`RCF_WDT_BIT])
			s_next.rst_en = 1'b1;

		s_next.irq = s_next.wif && s_next.wie && i_global_irq_enable;

		// read data
		if (i_core_access.rd && rcf_hit)
			s_next.rdata = {3'h0, s_reg.flags};
		else if (i_core_access.rd && wdc_hit)
			s_next.rdata = {s_reg.wif, wie_eff, s_reg.prescale[3], s_reg.wce,
				rst_en_eff, s_reg.prescale[2:0]};
		else if (i_core_access.rd)
			s_next.rdata = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge i_ref_clk or negedge rst_ok_reg)
	begin
		if (!rst_ok_reg)
		begin
			s_reg <= '0;
			s_reg.fuse_sync <= 2'h3;
			s_reg.flags <= `RCF_RESET;
		end
		else
			s_reg <= s_next;
	end

	assign o_rdata = s_reg.rdata;
	assign o_sys_reset = s_reg.sys_rst;
	assign o_wdt_irq = s_reg.irq;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!rst_ok_reg);

	sequence s_unlock;
		unlock_wr && !s_reg.sys_rst && !other_rst;
	endsequence

	sequence s_window_open;
		s_reg.wce && s_reg.ce_cnt == 3'h4;
	endsequence

	property p_dbg_flag;
		s_reg.dbg_sync[1] |=> s_reg.flags[`RCF_DBG_BIT];
	endproperty
	a_dbg_flag: assert property (p_dbg_flag) else $error("debug flag not set");

	property p_wdt_flag;
		s_reg.sys_rst |=> s_reg.flags[`RCF_WDT_BIT] && s_reg.rst_en;
	endproperty
	a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag not set");

	property p_bod_flag;
		s_reg.bod_sync[1] |=> s_reg.flags[`RCF_BOD_BIT];
	endproperty
	a_bod_flag: assert property (p_bod_flag) else $error("brown-out flag not set");

	property p_ext_flag;
		s_reg.ext_sync[1] |=> s_reg.flags[`RCF_EXT_BIT];
	endproperty
	a_ext_flag: assert property (p_ext_flag) else $error("external flag not set");

	property p_por_flag;
		$fell(s_reg.flags[`RCF_POR_BIT]) |-> $past(rcf_wr)
			&& !$past(i_core_access.wdata[`RCF_POR_BIT]);
	endproperty
	a_por_flag: assert property (p_por_flag) else $error("power-on flag lost");

	property p_ce_window;
		s_unlock |=> s_window_open ##1 (s_reg.ce_cnt == 3'h3 || !s_reg.wce);
	endproperty
	a_ce_window: assert property (p_ce_window) else $error("unlock window wrong");

	property p_ce_close;
		s_reg.wce && s_reg.ce_cnt == 3'h1 && !wdc_wr |=> !s_reg.wce;
	endproperty
	a_ce_close: assert property (p_ce_close) else $error("window not closed");

	property p_rst_en_hold;
		s_reg.flags[`RCF_WDT_BIT] |-> s_reg.rst_en;
	endproperty
	a_rst_en_hold: assert property (p_rst_en_hold) else $error("reset enable dropped");

	property p_irq;
		o_wdt_irq |-> s_reg.wif && s_reg.wie && $past(i_global_irq_enable);
	endproperty
	a_irq: assert property (p_irq) else $error("irq without cause");

	property p_rst_pulse;
		o_sys_reset |=> !o_sys_reset [*2];
	endproperty
	a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");

	property p_restart;
		i_wdt_restart && !other_rst |=> s_reg.wdt_cnt == 20'h0_0000;
	endproperty
	a_restart: assert property (p_restart) else $error("restart missed");

	property p_fuse_reset;
		timeout && fuse_prog && !other_rst |=> o_sys_reset;
	endproperty
	a_fuse_reset: assert property (p_fuse_reset) else $error("fuse reset missed");

	property p_cause_read;
		i_core_access.rd && rcf_hit |=> o_rdata[7:5] == 3'h0;
	endproperty
	a_cause_read: assert property (p_cause_read) else $error("reserved bits set");

endmodule
`default_nettype wire

/* test/core_bus_model.sv */
/*
 * core-side model: register loads and stores, and the slow oscillator.
 * assumes accesses are timed from the rising edge of i_ref_clk.
 */
`default_nettype none
module core_bus_model
	import watchdog_reset_status_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic [7:0] i_rdata,
	output core_access_t o_acc,
	output logic o_osc
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		o_acc = '0;
		o_osc = 1'b0;
		// oscillator stand-in, far faster than the real one to keep runs short
		forever #20 o_osc = ~o_osc;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic store(input logic [15:0] a, input logic ps, input logic [7:0] d);
		@(posedge i_ref_clk);
		o_acc <= '{addr: a, port_space: ps, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge i_ref_clk);
		o_acc <= '0;
	endtask
	task automatic load(input logic [15:0] a, input logic ps, output logic [7:0] d);
		@(posedge i_ref_clk);
		o_acc <= '{addr: a, port_space: ps, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge i_ref_clk);
		o_acc <= '0;
		@(posedge i_ref_clk);
		#1 d = i_rdata;
	endtask
	// timed unlock, then commit within the window
	task automatic unlock_store(input logic [7:0] d);
		store(16'h0060, 1'b0, 8'h18);
		store(16'h0060, 1'b0, d);
	endtask
endmodule
`default_nettype wire

/* test/test_watchdog_reset_status.sv */
/*
 * self-checking bench for the watchdog and reset-cause block.
 * assumes the core model drives accesses and the slow oscillator.
 */
`default_nettype none
module test_watchdog_reset_status
	import watchdog_reset_status_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_ref_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic restart = 1'b0;
	logic ack = 1'b0;
	logic gie = 1'b0;
	logic fuse = 1'b1;
	logic [2:0] src = 3'h0;
	logic [7:0] rdata;
	logic sys_reset;
	logic wdt_irq;
	logic osc;
	core_access_t acc;
	int failures = 0;
	int compares = 0;
	int n;
	always #5 i_ref_clk = ~i_ref_clk;
	core_bus_model core (.i_ref_clk(i_ref_clk), .i_rdata(rdata), .o_acc(acc), .o_osc(osc));
	watchdog_reset_status dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
		.i_core_access(acc), .i_wdt_restart(restart), .i_irq_ack(ack),
		.i_global_irq_enable(gie), .i_wdt_osc(osc), .i_always_on_fuse(fuse),
		.i_ext_reset(src[0]), .i_brownout_reset(src[1]), .i_debug_reset(src[2]),
		.o_rdata(rdata), .o_sys_reset(sys_reset), .o_wdt_irq(wdt_irq));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rd(input string what, input logic [15:0] a, input logic ps,
		input logic [7:0] exp);
		logic [7:0] d;
		core.load(a, ps, d);
		check(what, d, exp);
	endtask
	task automatic wait_for(const ref logic sig, input int lim);
		n = 0;
		while (sig !== 1'b1 && n < lim)
		begin
			@(posedge i_ref_clk);
			#1;
			n++;
		end
	endtask
	task automatic pulse(input int i);
		@(posedge i_ref_clk);
		if (i == 3) restart <= 1'b1; else if (i == 4) ack <= 1'b1; else src[i] <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		{restart, ack, src} <= '0;
		repeat (4) @(posedge i_ref_clk);
	endtask
	task automatic end_of_test();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_map();
		rd("cause data", 16'h0054, 1'b0, 8'h01);
		rd("cause port", 16'h0034, 1'b1, 8'h01);
		core.store(16'h0040, 1'b1, 8'h40);
		rd("ctrl port miss", 16'h0040, 1'b1, 8'h00);
		rd("ctrl data", 16'h0060, 1'b0, 8'h00);
		core.store(16'h0054, 1'b0, 8'hff);
		rd("cause upper", 16'h0054, 1'b0, 8'h01);
		$display("done map");
	endtask
	task automatic t_cause();
		logic [7:0] exp [3] = '{8'h02, 8'h04, 8'h10};
		for (int i = 0; i < 3; i++)
		begin
			core.store(16'h0054, 1'b0, 8'h00);
			pulse(i);
			rd("cause src", 16'h0054, 1'b0, exp[i]);
		end
		core.store(16'h0054, 1'b0, 8'h00);
		rd("cause clear", 16'h0054, 1'b0, 8'h00);
		$display("done cause");
	endtask
	task automatic t_window();
		core.store(16'h0060, 1'b0, 8'h08);
		core.store(16'h0060, 1'b0, 8'h21);
		rd("locked", 16'h0060, 1'b0, 8'h08);
		core.unlock_store(8'h29);
		rd("unlocked", 16'h0060, 1'b0, 8'h29);
		core.store(16'h0060, 1'b0, 8'h18);
		repeat (6) @(posedge i_ref_clk);
		rd("ce expired", 16'h0060, 1'b0, 8'h29);
		core.store(16'h0060, 1'b0, 8'h00);
		rd("late write", 16'h0060, 1'b0, 8'h29);
		$display("done window");
	endtask
	task automatic t_irq();
		pulse(3);
		core.unlock_store(8'h40);
		gie <= 1'b1;
		wait_for(wdt_irq, 12000);
		check("irq span", n > 8100 && n < 8250, 8'h01);
		rd("irq flag", 16'h0060, 1'b0, 8'hc0);
		gie <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
		check("irq masked", wdt_irq, 8'h00);
		gie <= 1'b1;
		pulse(4);
		check("irq acked", wdt_irq, 8'h00);
		rd("irq mode kept", 16'h0060, 1'b0, 8'h40);
		$display("done irq");
	endtask
	task automatic t_combined();
		pulse(3);
		core.store(16'h0060, 1'b0, 8'h48);
		wait_for(wdt_irq, 12000);
		check("combined irq", wdt_irq, 8'h01);
		check("no early reset", sys_reset, 8'h00);
		pulse(4);
		rd("ack to reset mode", 16'h0060, 1'b0, 8'h08);
		gie <= 1'b0;
		pulse(3);
		core.store(16'h0060, 1'b0, 8'h48);
		wait_for(sys_reset, 20000);
		check("two timeouts", n > 16300 && n < 16500, 8'h01);
		@(posedge i_ref_clk);
		#1;
		check("pulse width", sys_reset, 8'h00);
		rd("wdt flag", 16'h0054, 1'b0, 8'h08);
		core.unlock_store(8'h00);
		rd("reset enable held", 16'h0060, 1'b0, 8'h08);
		core.store(16'h0054, 1'b0, 8'h00);
		pulse(3);
		core.unlock_store(8'h00);
		rd("reset enable freed", 16'h0060, 1'b0, 8'h00);
		$display("done combined");
	endtask
	task automatic t_fuse();
		fuse <= 1'b0;
		pulse(3);
		rd("fuse mode", 16'h0060, 1'b0, 8'h08);
		wait_for(sys_reset, 10000);
		check("fuse reset", n < 10000, 8'h01);
		$display("done fuse");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (4) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		t_map();
		t_cause();
		t_window();
		t_irq();
		t_combined();
		t_fuse();
		end_of_test();
	end
	initial
	begin
		repeat (60000) @(posedge i_ref_clk);
		failures++;
		end_of_test();
	end
endmodule
`default_nettype wire
